/* File: rtl/nbil_loader.sv */
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - Boot header, directory and manufacturing data sit at fixed byte ranges.
// - Multi-byte values are big-endian, most significant byte first, except CRCs, checked least significant byte first.
// - Boot header accepted only if word zero equals the magic value.
// - Header word four is the scratch pad load and start address.
// - Header word eight is code length in words, including trailing CRC.
// - Header word twelve is the physical memory offset of the code.
// - Header CRC at sixteen covers header bytes zero to fifteen.
// - After reset the loader copies boot code to scratch pad then starts it.
// - Header length covers first phase only; second phase has own header.
// - Directory holds sixteen twelve-byte entries right after the header.
// - Entry word one is load address relative to the target processor.
// - Entry bits 31 to 28 hold image type; other codes reserved.
// - Entry bits 27 to 24 select target: none, host, management.
// - Entry bits 23 to 2 hold image length with CRC, two bits reserved.
// - Entry word three is the image byte offset in memory.
// - Directory CRC at 0xFC covers directory start through 0xFB.
// - Manufacturing region has ASCII revision and length 0x400 at offset two.
// - Port swap equals config bit 2 XOR the swap strap.
// - Config bit 15 makes spare pin four follow PERST, low when asserted.
// - Config bit 12 selects SMBus 100 kHz or 400 kHz.
// - Identity and power fields are copied to the endpoint identity logic.
module nbil_loader
  import nbil_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic [23:0] mem_addr,
  output logic mem_rd,
  input wire logic mem_vld,
  input wire logic [7:0] mem_data,
  output logic [15:0] spad_addr,
  output logic spad_wr,
  output logic [31:0] spad_data,
  output logic mgmt_start,
  output logic [31:0] mgmt_start_addr,
  input wire logic port_swap_strap,
  input wire logic perst_n,
  output logic port_swap,
  output logic spare_pin_four_out,
  output logic spare_pin_four_oe,
  output logic smbus_fast,
  output logic [31:0] id_pci,
  output logic [31:0] id_pci_sub,
  output logic [31:0] id_pwr_dis,
  output logic [31:0] id_pwr_con,
  output logic id_valid,
  output logic [15:0] dir_entry_ok,
  output logic [3:0] dir_boot2_idx,
  output logic dir_boot2_found,
  output logic [31:0] dir_boot2_ofs,
  output logic [21:0] dir_boot2_len,
  output logic load_done,
  output logic load_err,
  output logic [1:0] load_err_code,
  input wire logic [31:0] mgmt_err_clr
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ NBIL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic last_word(input logic [15:0] n, input logic [31:0] len);
    return ({16'h0000, n} + 32'h00000001) >= len;
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic swap_s1_q, swap_s2_q, perst_s1_q, perst_s2_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      swap_s1_q <= 1'b0;
      swap_s2_q <= 1'b0;
      perst_s1_q <= 1'b0;
      perst_s2_q <= 1'b0;
    end else begin
      swap_s1_q <= port_swap_strap;
      swap_s2_q <= swap_s1_q;
      perst_s1_q <= perst_n;
      perst_s2_q <= perst_s1_q;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum {
    NBIL_S_HDR, NBIL_S_DIR, NBIL_S_MFG, NBIL_S_CODE, NBIL_S_DONE, NBIL_S_FAIL
  } nbil_state_t;
  nbil_state_t st_q;

  logic [23:0] addr_q;
  logic rd_q;
  logic [1:0] bcnt_q;
  logic [31:0] word_d, word_q;
  logic [31:0] crc_q;
  logic [15:0] wcnt_q;
  logic [31:0] hdr_q [0:3];
  logic [31:0] ent_q [0:2];
  logic [31:0] cfg_q, cfg2_q;
  logic [15:0] mfg_len_q;
  logic word_end;
  logic [31:0] code_words;
  logic crc_good;
  logic code_last;

  assign word_d = {word_q[23:0], mem_data};
  assign word_end = mem_vld && (bcnt_q == 2'h3);
  assign code_words = hdr_q[2];
  // Running CRC with the arriving byte folded in, held against the residue
  assign crc_good = (crc_byte(crc_q, mem_data) == NBIL_CRC_RESIDUE);
  assign code_last = last_word(wcnt_q, code_words);

  assign mem_addr = addr_q;
  assign mem_rd = rd_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      word_q <= 32'h00000000;
      bcnt_q <= 2'h0;
    end else if (mem_vld) begin
      word_q <= word_d;
      bcnt_q <= bcnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= NBIL_S_HDR;
      addr_q <= NBIL_BOOT_BASE;
      rd_q <= 1'b1;
      wcnt_q <= 16'h0000;
      crc_q <= NBIL_CRC_INIT;
      load_err_code <= NBIL_ERR_NONE;
      for (int i = 0; i < 4; i++) begin
        hdr_q[i] <= 32'h00000000;
      end
    end else begin
      if (mem_vld) begin
        addr_q <= addr_q + 24'h000001;
        crc_q <= crc_byte(crc_q, mem_data);
      end
      case (st_q)
        NBIL_S_HDR: begin
          if (word_end) begin
            wcnt_q <= wcnt_q + 16'h0001;
            if (wcnt_q < 16'h0004) begin
              hdr_q[wcnt_q[1:0]] <= word_d;
            end
            if (wcnt_q == 16'h0000 && word_d != NBIL_MAGIC) begin
              st_q <= NBIL_S_FAIL;
              load_err_code <= NBIL_ERR_MAGIC;
              rd_q <= 1'b0;
            end else if (wcnt_q == 16'(NBIL_HDR_WORDS - 5'h01)) begin
              if (!crc_good) begin
                st_q <= NBIL_S_FAIL;
                load_err_code <= NBIL_ERR_HDR_CRC;
                rd_q <= 1'b0;
              end else begin
                st_q <= NBIL_S_DIR;
                wcnt_q <= 16'h0000;
                crc_q <= NBIL_CRC_INIT;
              end
            end
          end
        end
        NBIL_S_DIR: begin
          if (word_end) begin
            wcnt_q <= wcnt_q + 16'h0001;
            if (wcnt_q == 16'(NBIL_DIR_WORDS - 6'h01)) begin
              // Directory CRC only flags; boot code still has its own check
              load_err_code <= !crc_good ?
                NBIL_ERR_HDR_CRC : load_err_code;
              st_q <= NBIL_S_MFG;
              wcnt_q <= 16'h0000;
              addr_q <= NBIL_MFG_BASE;
            end
          end
        end
        NBIL_S_MFG: begin
          if (mem_vld && addr_q == NBIL_PWR_CON_OFS + 24'h000003) begin
            st_q <= NBIL_S_CODE;
            addr_q <= hdr_q[3][23:0];
            wcnt_q <= 16'h0000;
            crc_q <= NBIL_CRC_INIT;
          end
        end
        NBIL_S_CODE: begin
          if (word_end) begin
            wcnt_q <= wcnt_q + 16'h0001;
            if (code_last) begin
              rd_q <= 1'b0;
              if (!crc_good) begin
                st_q <= NBIL_S_FAIL;
                load_err_code <= NBIL_ERR_IMG_CRC;
              end else begin
                st_q <= NBIL_S_DONE;
              end
            end
          end
        end
        NBIL_S_DONE: rd_q <= 1'b0;
        NBIL_S_FAIL: rd_q <= 1'b0;
        default: st_q <= NBIL_S_FAIL;
      endcase
    end
  end

  // ----------------------------------------
  // Scratch pad copy
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      spad_wr <= 1'b0;
      spad_addr <= 16'h0000;
      spad_data <= 32'h00000000;
    end else begin
      spad_wr <= (st_q == NBIL_S_CODE) && word_end && !code_last;
      spad_addr <= hdr_q[1][15:0] + {wcnt_q[13:0], 2'b00};
      spad_data <= word_d;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mgmt_start <= 1'b0;
      mgmt_start_addr <= 32'h00000000;
      load_done <= 1'b0;
    end else begin
      mgmt_start <= (st_q == NBIL_S_CODE) && crc_good && word_end && code_last;
      mgmt_start_addr <= hdr_q[1];
      load_done <= (st_q == NBIL_S_DONE);
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Mask only hides the flag; the cause code keeps its value
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      load_err <= 1'b0;
    end else begin
      load_err <= (load_err_code != NBIL_ERR_NONE) && !mgmt_err_clr[0];
    end
  end

  // Strap passes the synchroniser first, so a flip shows three cycles later
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      port_swap <= 1'b0;
    end else begin
      port_swap <= cfg_q[NBIL_CFG_SWAP_BIT] ^ swap_s2_q;
    end
  end

  // ----------------------------------------
  // Directory parsing
  // ----------------------------------------
  logic [1:0] ent_w_q;
  logic [3:0] ent_i_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ent_w_q <= 2'h0;
      ent_i_q <= 4'h0;
      dir_entry_ok <= 16'h0000;
      dir_boot2_found <= 1'b0;
      dir_boot2_idx <= 4'h0;
      dir_boot2_ofs <= 32'h00000000;
      dir_boot2_len <= 22'h000000;
      for (int i = 0; i < 3; i++) begin
        ent_q[i] <= 32'h00000000;
      end
    end else if (st_q == NBIL_S_DIR && word_end && wcnt_q < 16'h0030) begin
      ent_q[ent_w_q] <= word_d;
      ent_w_q <= (ent_w_q == 2'h2) ? 2'h0 : ent_w_q + 2'h1;
      if (ent_w_q == 2'h2) begin
        ent_i_q <= ent_i_q + 4'h1;
        // Entry is usable when its target is defined and length nonzero
        dir_entry_ok[ent_i_q] <= (ent_q[1][NBIL_TGT_HI -: 4] <= NBIL_TGT_MGMT) &&
          (ent_q[1][NBIL_LEN_HI:2] != 22'h000000);
        if (!dir_boot2_found && ent_q[1][NBIL_TYPE_HI -: 4] == NBIL_TYPE_BOOT2 &&
            ent_q[1][NBIL_TGT_HI -: 4] == NBIL_TGT_MGMT) begin
          dir_boot2_found <= 1'b1;
          dir_boot2_idx <= ent_i_q;
          dir_boot2_ofs <= word_d;
          dir_boot2_len <= ent_q[1][NBIL_LEN_HI:2];
        end
      end
    end
  end

  // ----------------------------------------
  // Manufacturing fields
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= 32'h00000000;
      cfg2_q <= 32'h00000000;
      mfg_len_q <= 16'h0000;
      id_pci <= 32'h00000000;
      id_pci_sub <= 32'h00000000;
      id_pwr_dis <= 32'h00000000;
      id_pwr_con <= 32'h00000000;
      id_valid <= 1'b0;
    end else begin
      if (st_q == NBIL_S_MFG && mem_vld) begin
        case (addr_q - 24'h000003)
          NBIL_MFG_CFG_OFS: cfg_q <= word_d;
          NBIL_MFG_CFG2_OFS: cfg2_q <= word_d;
          NBIL_PCI_ID_OFS: id_pci <= word_d;
          NBIL_PCI_SUB_OFS: id_pci_sub <= word_d;
          NBIL_PWR_DIS_OFS: id_pwr_dis <= word_d;
          NBIL_PWR_CON_OFS: id_pwr_con <= word_d;
          default: ;
        endcase
        if (addr_q == NBIL_MFG_LEN_OFS + 24'h000001) begin
          mfg_len_q <= word_d[15:0];
        end
      end
      id_valid <= (st_q == NBIL_S_CODE || st_q == NBIL_S_DONE) && (mfg_len_q == NBIL_MFG_LEN);
    end
  end

  assign smbus_fast = cfg2_q[NBIL_CFG2_SMB_BIT];
  assign spare_pin_four_oe = cfg2_q[NBIL_CFG2_PERST_BIT];
  assign spare_pin_four_out = perst_s2_q;

endmodule

/* File: rtl/nbil_pkg.sv */
package nbil_pkg;

  // ----------------------------------------
  // Memory map of the non-volatile image
  // ----------------------------------------
  localparam logic [23:0] NBIL_BOOT_BASE = 24'h000000;
  localparam logic [23:0] NBIL_DIR_BASE = 24'h000014;
  localparam logic [23:0] NBIL_DIR_CRC_OFS = 24'h0000FC;
  localparam logic [23:0] NBIL_MFG_BASE = 24'h000100;
  localparam logic [23:0] NBIL_MFG_LEN_OFS = 24'h000102;
  localparam logic [23:0] NBIL_MFG_CFG_OFS = 24'h000114;
  localparam logic [23:0] NBIL_MFG_CFG2_OFS = 24'h000118;
  localparam logic [23:0] NBIL_PCI_ID_OFS = 24'h00012C;
  localparam logic [23:0] NBIL_PCI_SUB_OFS = 24'h000130;
  localparam logic [23:0] NBIL_PWR_DIS_OFS = 24'h000134;
  localparam logic [23:0] NBIL_PWR_CON_OFS = 24'h000138;
  localparam logic [23:0] NBIL_MFG_END = 24'h00044F;

  // ----------------------------------------
  // Header and directory layout
  // ----------------------------------------
  localparam logic [31:0] NBIL_MAGIC = 32'h669955AA;
  localparam logic [4:0] NBIL_HDR_WORDS = 5'h05;
  localparam logic [5:0] NBIL_DIR_WORDS = 6'h3B;
  localparam logic [4:0] NBIL_DIR_ENTRIES = 5'h10;
  localparam logic [15:0] NBIL_MFG_LEN = 16'h0400;
  localparam int NBIL_TYPE_HI = 31;
  localparam int NBIL_TGT_HI = 27;
  localparam int NBIL_LEN_HI = 23;
  localparam int NBIL_CFG_SWAP_BIT = 2;
  localparam int NBIL_CFG2_SMB_BIT = 12;
  localparam int NBIL_CFG2_PERST_BIT = 15;
  localparam logic [3:0] NBIL_TYPE_BOOT2 = 4'h0;
  localparam logic [3:0] NBIL_TYPE_BOOT1 = 4'hE;
  localparam logic [3:0] NBIL_TGT_MGMT = 4'h2;
  localparam logic [15:0] NBIL_ROM_BYTES = 16'h0400;
  localparam logic [31:0] NBIL_CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] NBIL_CRC_POLY = 32'hEDB88320;
  // Register value left after a CRC run over data followed by its stored CRC
  localparam logic [31:0] NBIL_CRC_RESIDUE = 32'hDEBB20E3;

  typedef enum logic [1:0] {
    NBIL_ERR_NONE,
    NBIL_ERR_MAGIC,
    NBIL_ERR_HDR_CRC,
    NBIL_ERR_IMG_CRC
  } nbil_err_t;

endpackage

/* File: tb/nbil_loader_asserts.sv */
`timescale 1ns/1ps
module nbil_loader_asserts
  import nbil_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_vld,
  input wire logic spad_wr,
  input wire logic mgmt_start,
  input wire logic port_swap_strap,
  input wire logic perst_n,
  input wire logic port_swap,
  input wire logic spare_pin_four_out,
  input wire logic load_done,
  input wire logic load_err,
  input wire logic [1:0] load_err_code,
  input wire logic [31:0] mgmt_err_clr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_rst_fetch_base: assert property ($fell(sys_rst) |-> mem_rd && mem_addr == NBIL_BOOT_BASE)
    else $error("fetch does not start at byte zero");
  a_fetch_step: assert property (mem_vld && mem_rd && (mem_addr inside {[24'h04:24'h12], [24'h14:24'hFE]})
    |=> mem_addr == $past(mem_addr) + 24'h1) else $error("fetch address did not step by one");
  a_spad_after_byte: assert property (spad_wr |-> $past(mem_vld))
    else $error("scratch pad write without a fresh byte");
  a_spad_spacing: assert property (spad_wr |=> !spad_wr [*3])
    else $error("scratch pad writes closer than four bytes");
  a_start_clean: assert property (mgmt_start |-> load_err_code != NBIL_ERR_MAGIC
    && load_err_code != NBIL_ERR_IMG_CRC) else $error("start after failed check");
  a_start_done: assert property (mgmt_start |-> ##[0:3] load_done)
    else $error("start without load done");
  a_magic_no_copy: assert property (load_err_code == NBIL_ERR_MAGIC |-> !spad_wr && !mgmt_start)
    else $error("code copied after bad magic");
  a_err_flag: assert property (load_err == $past(load_err_code != 2'h0 && !mgmt_err_clr[0]))
    else $error("error flag does not match code and mask");
  a_spare_follow: assert property ($stable(perst_n) [*4] |-> spare_pin_four_out == perst_n)
    else $error("spare pin does not follow reset input");
  a_swap_xor: assert property (load_done && $changed(port_swap_strap) ##1 $stable(port_swap_strap) [*4]
    |-> port_swap != $past(port_swap, 5)) else $error("port swap ignores strap");

  c_start: cover property (mgmt_start);
  c_magic: cover property (load_err_code == NBIL_ERR_MAGIC);
  c_code_crc: cover property (load_err_code == NBIL_ERR_IMG_CRC);
  c_perst: cover property ($fell(perst_n));
endmodule

bind nbil_loader nbil_loader_asserts i_nbil_loader_asserts (.clk_sys, .sys_rst, .mem_addr, .mem_rd, .mem_vld,
  .spad_wr, .mgmt_start, .port_swap_strap, .perst_n, .port_swap, .spare_pin_four_out, .load_done, .load_err,
  .load_err_code, .mgmt_err_clr);

/* File: tb/nbil_mem_model.sv */
`timescale 1ns/1ps
module nbil_mem_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  output logic mem_vld,
  output logic [7:0] mem_data,
  input wire logic [3:0] gap
);
  // Image words are laid down most significant byte first by the bench, CRC words least significant byte first
  logic [7:0] mem [0:2047];
  logic [3:0] wait_q;
  logic [7:0] last_q;

  // ----------------------------------------
  // Byte server, gap cycles of delay per byte
  // ----------------------------------------
  assign mem_vld = mem_rd && (wait_q >= gap);
  // Idle data lines show the inverse of the last byte, never a stale copy
  assign mem_data = mem_vld ? mem[mem_addr[10:0]] : ~last_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 4'h0;
      last_q <= 8'h00;
    end else if (mem_vld) begin
      wait_q <= 4'h0;
      last_q <= mem_data;
    end else if (mem_rd) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

/* File: tb/test_nbil_loader.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module test_nbil_loader;
  import nbil_pkg::*;
  typedef struct {int bad; logic strap; logic [31:0] cfg; logic [31:0] cfg2; logic [3:0] gap; logic clr;
    logic [1:0] err; logic start;} nbil_row_t;
  // Arbitrary identity values
  localparam logic [31:0] ID0 = 32'h5A5A0001;
  localparam logic [31:0] CODE [3] = '{32'hA1B2C3D4, 32'h0F1E2D3C, 32'h55667788};
  logic clk_sys = 1'b0, sys_rst = 1'b1, port_swap_strap = 1'b0, perst_n = 1'b1;
  logic [31:0] mgmt_err_clr = 32'h0;
  logic [3:0] gap = 4'h0;
  logic [23:0] mem_addr;
  logic [7:0] mem_data;
  logic [15:0] spad_addr, first_wa, dir_entry_ok;
  logic [31:0] spad_data, mgmt_start_addr, id_pci, id_pci_sub, id_pwr_dis, id_pwr_con, dir_boot2_ofs;
  logic mem_rd, mem_vld, spad_wr, mgmt_start, port_swap, spare_pin_four_out, spare_pin_four_oe, smbus_fast;
  logic id_valid, dir_boot2_found, load_done, load_err;
  logic [3:0] dir_boot2_idx;
  logic [21:0] dir_boot2_len;
  logic [1:0] load_err_code;
  logic [31:0] wr_q [$];
  int n_errors = 0, cmp_count = 0, n_start = 0;
  nbil_row_t rows [7] = '{
    '{0, 1'b0, 32'h4, 32'h9000, 4'h0, 1'b0, 2'h0, 1'b1},
    '{0, 1'b1, 32'h4, 32'h0, 4'h2, 1'b0, 2'h0, 1'b1},
    '{1, 1'b0, 32'h0, 32'h0, 4'h0, 1'b0, 2'h1, 1'b0},
    '{2, 1'b0, 32'h0, 32'h0, 4'h0, 1'b0, 2'h2, 1'b0},
    '{3, 1'b0, 32'h0, 32'h0, 4'h1, 1'b0, 2'h3, 1'b0},
    '{4, 1'b1, 32'h0, 32'h8000, 4'h0, 1'b0, 2'h2, 1'b1},
    '{3, 1'b0, 32'h0, 32'h0, 4'h0, 1'b1, 2'h3, 1'b0}};

  nbil_loader i_nbil_loader (.clk_sys, .sys_rst, .mem_addr, .mem_rd, .mem_vld, .mem_data, .spad_addr, .spad_wr,
    .spad_data, .mgmt_start, .mgmt_start_addr, .port_swap_strap, .perst_n, .port_swap, .spare_pin_four_out,
    .spare_pin_four_oe, .smbus_fast, .id_pci, .id_pci_sub, .id_pwr_dis, .id_pwr_con, .id_valid, .dir_entry_ok,
    .dir_boot2_idx, .dir_boot2_found, .dir_boot2_ofs, .dir_boot2_len, .load_done, .load_err, .load_err_code,
    .mgmt_err_clr);
  nbil_mem_model i_nbil_mem_model (.clk_sys, .sys_rst, .mem_addr, .mem_rd, .mem_vld, .mem_data, .gap);

  always #25 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (spad_wr === 1'b1) begin
      if (wr_q.size() == 0) first_wa = spad_addr;
      wr_q.push_back(spad_data);
    end
    if (mgmt_start === 1'b1) n_start++;
  end

  // ----------------------------------------
  // Image building
  // ----------------------------------------
  task automatic put32(int a, logic [31:0] v);
    for (int i = 0; i < 4; i++) i_nbil_mem_model.mem[a + i] = v[31 - 8 * i -: 8];
  endtask

  task automatic put_crc(int a, int n);
    logic [31:0] c;
    c = NBIL_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, i_nbil_mem_model.mem[a + i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ NBIL_CRC_POLY : c >> 1;
    end
    for (int i = 0; i < 4; i++) i_nbil_mem_model.mem[a + n + i] = ~c[8 * i +: 8];
  endtask

  task automatic build(nbil_row_t r);
    for (int i = 0; i < 2048; i++) i_nbil_mem_model.mem[i] = 8'h00;
    put32(0, NBIL_MAGIC);
    put32(4, 32'h08000100);
    put32(8, 32'h4);
    put32(12, 32'h200);
    put_crc(0, 16);
    // Unused entries carry a reserved type so that only entry two qualifies
    for (int e = 0; e < 16; e++) put32(24 + 12 * e, 32'hF0000000);
    put32(32'h24, {NBIL_TYPE_BOOT1, NBIL_TGT_MGMT, 22'h4, 2'b00});
    put32(32'h2C, 32'h08002000);
    put32(32'h30, {NBIL_TYPE_BOOT2, NBIL_TGT_MGMT, 22'h4, 2'b00});
    put32(32'h34, 32'h300);
    put_crc(32'h14, 32'hE8);
    put32(32'h100, 32'h41000400);
    put32(32'h114, r.cfg);
    put32(32'h118, r.cfg2);
    for (int i = 0; i < 4; i++) put32(32'h12C + 4 * i, ID0 + 32'(i));
    for (int i = 0; i < 3; i++) put32(32'h200 + 4 * i, CODE[i]);
    put_crc(32'h200, 12);
    case (r.bad)
      1: i_nbil_mem_model.mem[0] ^= 8'h01;
      2: i_nbil_mem_model.mem[32'h10] ^= 8'h01;
      3: i_nbil_mem_model.mem[32'h20C] ^= 8'h01;
      4: i_nbil_mem_model.mem[32'hFC] ^= 8'h01;
      default: ;
    endcase
  endtask

  // ----------------------------------------
  // Boot run and result checks
  // ----------------------------------------
  task automatic boot(nbil_row_t r, bit abort);
    sys_rst <= 1'b1;
    gap <= r.gap;
    port_swap_strap <= r.strap;
    mgmt_err_clr <= {31'h0, r.clr};
    build(r);
    wr_q.delete();
    n_start = 0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    if (abort) begin
      repeat (150) @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
    end
    for (int i = 0; i < 6000 && mem_rd !== 1'b0; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic check(nbil_row_t r);
    `CHK(load_err_code, r.err)
    `CHK(load_err, (r.err != 2'h0) && !r.clr)
    `CHK(n_start, int'(r.start))
    if (r.err inside {2'h1, 2'h2} && !r.start) `CHK(wr_q.size(), 0)
    if (r.start) begin
      `CHK(mgmt_start_addr, 32'h08000100)
      `CHK(first_wa, 16'h0100)
      `CHK(wr_q.size(), 3)
      foreach (wr_q[i]) `CHK(wr_q[i], CODE[i])
      `CHK({dir_boot2_found, dir_boot2_idx, dir_boot2_ofs, dir_boot2_len}, {1'b1, 4'h2, 32'h300, 22'h4})
      `CHK(dir_entry_ok, 16'h0006)
      `CHK({port_swap, smbus_fast, spare_pin_four_oe}, {r.cfg[2] ^ r.strap, r.cfg2[12], r.cfg2[15]})
      `CHK({id_valid, id_pci, id_pci_sub}, {1'b1, ID0, ID0 + 32'h1})
      `CHK({id_pwr_dis, id_pwr_con}, {ID0 + 32'h2, ID0 + 32'h3})
      perst_n <= 1'b0;
      port_swap_strap <= ~r.strap;
      repeat (5) @(posedge clk_sys);
      `CHK({spare_pin_four_out, port_swap}, {1'b0, r.cfg[2] ^ ~r.strap})
      perst_n <= 1'b1;
      port_swap_strap <= r.strap;
      repeat (5) @(posedge clk_sys);
      `CHK(spare_pin_four_out, 1'b1)
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    foreach (rows[i]) begin
      boot(rows[i], 1'b0);
      check(rows[i]);
    end
    // Reset in mid-directory, then a full clean boot
    boot(rows[1], 1'b1);
    check(rows[1]);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK({mem_rd, mem_addr, load_done, mgmt_start, id_valid, load_err_code}, {1'b1, 24'h0, 5'h00})
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end
endmodule
